// ---- bench/spi_master_model.sv ----
`timescale 1ns/1ps

// Bus master on the far side of the link, bit-banged from the system clock
module spi_master_model (
    // Timing reference
    input wire logic sys_clk_i,
    // Link pins
    output logic sck_o,
    output logic cs_b_o,
    output logic mosi_o,
    output logic hold_b_o
);
    // Deselected at power-up; shared reset line never pulled low mid-write
    initial begin
        sck_o = 1'b0;
        cs_b_o = 1'b1;
        mosi_o = 1'b0;
        hold_b_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Half of the 160 ns link period
    task automatic wait_half();
        repeat (4) @(negedge sys_clk_i);
    endtask : wait_half

    // Park clock for the mode while deselected, then a falling select
    task automatic start(input logic mode3);
        sck_o = mode3;
        wait_half();
        cs_b_o = 1'b0;
        wait_half();
    endtask : start

    // Launch on the low phase, device samples on the rise
    task automatic send_bits(input logic [7:0] b, input int hi, input int lo);
        for (int i = hi; i >= lo; i--) begin
            sck_o = 1'b0;
            mosi_o = b[i];
            wait_half();
            sck_o = 1'b1;
            wait_half();
        end
    endtask : send_bits

    // Pause pin; released high to continue the same sequence
    task automatic set_hold(input logic level);
        hold_b_o = level;
    endtask : set_hold

    // Clock back to its park level, then deselect; data no longer valid
    task automatic stop(input logic mode3);
        sck_o = mode3;
        wait_half();
        cs_b_o = 1'b1;
        mosi_o = ~mosi_o;
        wait_half();
    endtask : stop
endmodule : spi_master_model

// ---- bench/test_serial_flash_bus_interface.sv ----
`timescale 1ns/1ps

module test_serial_flash_bus_interface;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic qe = 1'b0;
    logic role = 1'b0;
    logic tx_en = 1'b0;
    logic wp = 1'b1;
    logic quad_mode = 1'b0;
    logic hw_rst_b = 1'b1;
    int rises = 0;
    logic [7:0] tx_byte = 8'h00;
    logic sck, cs_b, mosi, hold_b;
    logic [3:0] dout, oe_b;
    logic [7:0] rx_byte, b32, bytes[4];
    logic rx_valid, addr_valid, selected, paused, in_reset, mode3;
    logic [2:0] byte_index;
    logic [23:0] addr;
    logic [10:0] sector;
    logic [6:0] b64;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int samples_checked = 0;
    int exp_addr;

    // 50 MHz system clock
    always #10 sys_clk_i = ~sys_clk_i;

    spi_master_model master (.sys_clk_i(sys_clk_i), .sck_o(sck), .cs_b_o(cs_b),
        .mosi_o(mosi), .hold_b_o(hold_b));

    // Released lines fall back to the master, to wp on line 2, or to a pull-up on line 1
    serial_flash_bus_interface #(.HAS_DEDICATED_RESET(1'b0)) uut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .chip_select_b_i(cs_b),
        .hw_reset_b_i(hw_rst_b), .data_line_0_i(oe_b[0] ? mosi : dout[0]),
        .data_line_0_o(dout[0]), .data_line_0_oe_b_o(oe_b[0]),
        .data_line_1_i(oe_b[1] ? 1'b1 : dout[1]),
        .data_line_1_o(dout[1]), .data_line_1_oe_b_o(oe_b[1]),
        .data_line_2_i(oe_b[2] ? wp : dout[2]),
        .data_line_2_o(dout[2]), .data_line_2_oe_b_o(oe_b[2]),
        .data_line_3_i(oe_b[3] ? hold_b : dout[3]),
        .data_line_3_o(dout[3]), .data_line_3_oe_b_o(oe_b[3]),
        .quad_io_enable_i(qe), .pause_or_init_select_i(role), .quad_command_mode_i(quad_mode),
        .tx_en_i(tx_en), .tx_byte_i(tx_byte), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
        .byte_index_o(byte_index), .selected_o(selected), .paused_o(paused),
        .in_reset_o(in_reset), .mode3_o(mode3), .addr_o(addr), .sector_o(sector),
        .block32_o(b32), .block64_o(b64), .addr_valid_o(addr_valid));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic complete_run();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // Every result pulse against the reference model
    always @(negedge sys_clk_i) begin
        if (rx_valid === 1'b1) begin
            check(rx_byte, exp_q.pop_front());
        end
        if (addr_valid === 1'b1) begin
            check(addr, 24'(exp_addr));
            check(sector, 24'(exp_addr >> 12));
            check(b32, 24'(exp_addr >> 15));
            check(b64, 24'(exp_addr >> 16));
        end
    end

    // Serial output at each rise; bytes 1 to 3 carry the loaded transmit byte
    always @(posedge sck or posedge cs_b) begin
        if (cs_b === 1'b1) begin
            rises = 0;
        end else begin
            if (rises >= 8 && rises < 32) begin
                check(dout[1], tx_byte[7 - rises % 8]);
            end
            rises++;
        end
    end

    // Generous bound: the whole sequence needs about 20 us
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Pass 0 mode 0, pass 1 mode 3, pass 2 quad enable set
    initial begin
        void'($urandom(32'hf83f8d3d));
        repeat (16) @(negedge sys_clk_i);
        check(oe_b, flash_bus_pkg::OE_NONE);
        check(in_reset, 1'b1);
        rst_b_i = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        for (int p = 0; p < 3; p++) begin
            qe = (p == 2);
            tx_en = 1'b1;
            tx_byte = 8'($urandom);
            wp = 1'($urandom);
            for (int k = 0; k < 4; k++) bytes[k] = 8'($urandom);
            exp_addr = {bytes[1], bytes[2], bytes[3]} % 32'h0080_0000;
            master.start(p == 1);
            repeat (12) @(negedge sys_clk_i);
            check(mode3, p == 1);
            check(selected, 1'b1);
            for (int k = 0; k < 4; k++) begin
                exp_q.push_back(bytes[k]);
                if (k == 2) begin
                    master.send_bits(bytes[k], 7, 4);
                    check(oe_b, flash_bus_pkg::OE_SINGLE);
                    master.set_hold(1'b0);
                    repeat (10) @(negedge sys_clk_i);
                    check(paused, p != 2);
                    check(oe_b[1], p != 2);
                    master.set_hold(1'b1);
                    // Let the release settle so the next clock fall is not lost
                    repeat (4) @(negedge sys_clk_i);
                    master.send_bits(bytes[k], 3, 0);
                end else begin
                    master.send_bits(bytes[k], 7, 0);
                end
            end
            repeat (6) @(negedge sys_clk_i);
            check(byte_index, 3'h4);
            master.stop(p == 1);
            repeat (6) @(negedge sys_clk_i);
            check(selected, 1'b0);
            check(oe_b, flash_bus_pkg::OE_NONE);
        end
        // Quad command mode drives all four lines
        qe = 1'b1;
        quad_mode = 1'b1;
        master.start(1'b0);
        repeat (8) @(negedge sys_clk_i);
        check(oe_b, flash_bus_pkg::OE_QUAD);
        master.stop(1'b0);
        repeat (6) @(negedge sys_clk_i);
        check(oe_b, flash_bus_pkg::OE_NONE);
        quad_mode = 1'b0;
        // Shared pin in its reset role
        qe = 1'b0;
        role = 1'b1;
        master.set_hold(1'b0);
        repeat (8) @(negedge sys_clk_i);
        check(in_reset, 1'b1);
        check(oe_b, flash_bus_pkg::OE_NONE);
        master.set_hold(1'b1);
        repeat (8) @(negedge sys_clk_i);
        check(exp_q.size(), 24'h00_0000);
        // Build without a dedicated reset ignores that pin
        hw_rst_b = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        check(in_reset, 1'b0);
        hw_rst_b = 1'b1;
        complete_run();
    end
endmodule : test_serial_flash_bus_interface

// ---- hw/flash_addr_decode.sv ----
`timescale 1ns/1ps

// Splits a captured byte address into sector and block numbers
module flash_addr_decode (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Captured address
    input wire logic [flash_bus_pkg::ADDR_W-1:0] addr_i,
    input wire logic strobe_i,
    // Decoded location
    output logic [flash_bus_pkg::ADDR_W-1:0] addr_o,
    output logic [flash_bus_pkg::SECTOR_W-1:0] sector_o,
    output logic [flash_bus_pkg::BLK32_W-1:0] block32_o,
    output logic [flash_bus_pkg::BLK64_W-1:0] block64_o,
    output logic addr_valid_o
);

    logic [flash_bus_pkg::ADDR_W-1:0] addr_reg, addr_next, addr_cut;
    logic [flash_bus_pkg::SECTOR_W-1:0] sector_reg, sector_next;
    logic [flash_bus_pkg::BLK32_W-1:0] blk32_reg, blk32_next;
    logic [flash_bus_pkg::BLK64_W-1:0] blk64_reg, blk64_next;
    logic valid_reg, valid_next;

    // Top address bit wraps, the array ends at the last sector
    always_comb begin
        addr_cut = addr_i & flash_bus_pkg::ADDR_MAX; // see [RULE13]
        addr_next = addr_reg;
        sector_next = sector_reg;
        blk32_next = blk32_reg;
        blk64_next = blk64_reg;
        valid_next = strobe_i;
        if (strobe_i) begin
            addr_next = addr_cut;
            sector_next = flash_bus_pkg::SECTOR_W'(addr_cut >> flash_bus_pkg::SECTOR_SHIFT); // see [RULE11]
            blk32_next = flash_bus_pkg::BLK32_W'(addr_cut >> flash_bus_pkg::BLK32_SHIFT); // see [RULE12]
            blk64_next = flash_bus_pkg::BLK64_W'(addr_cut >> flash_bus_pkg::BLK64_SHIFT); // see [RULE12]
        end
    end

    // Result registers
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_reg <= '0;
            sector_reg <= '0;
            blk32_reg <= '0;
            blk64_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            sector_reg <= sector_next;
            blk32_reg <= blk32_next;
            blk64_reg <= blk64_next;
            valid_reg <= valid_next;
        end
    end

    assign addr_o = addr_reg;
    assign sector_o = sector_reg;
    assign block32_o = blk32_reg;
    assign block64_o = blk64_reg;
    assign addr_valid_o = valid_reg;

    // Blocks are whole groups of eight or sixteen sectors
    AST_BLOCK_ALIGN: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // see [RULE12]
        addr_valid_o |-> (block32_o == sector_o[10:3]) && (block64_o == sector_o[10:4]))
        else $error("block number not aligned to its sectors");

endmodule : flash_addr_decode

// ---- hw/serial_flash_bus_interface.sv ----
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Quad enable set makes the shared pin data line 3, else pause input.
// [RULE2] Selected and paused: serial output is released.
// [RULE3] Pause freezes the transfer; it continues where it stopped.
// [RULE4] Dedicated reset input, when built, works whatever quad enable says.
// [RULE5] Reset low holds the block reset with every output released.
// [RULE6] Master must not reset during an internal write, program or erase.
// [RULE7] Clock modes 0 and 3 accepted, chosen by clock level at select.
// [RULE8] Master parks clock low for mode 0, high for mode 3.
// [RULE9] Bits sampled on rising clock edge, launched on falling edge.
// [RULE10] Quad command mode uses all four pins as data lines.
// [RULE11] Array is made of uniform 4 kilobyte sectors.
// [RULE12] Eight sectors form a 32 KB block, sixteen a 64 KB block.
// [RULE13] Addresses 000000h to 7FFFFFh: 2048 sectors, 256 and 128 blocks.
// [RULE14] Shared bus; the block answers only to its own chip select.
// [RULE15] Chip select high: ignore the bus, release outputs, stand by.
// [RULE16] After power-up no instruction until chip select falls from high.
// [RULE17] Without dedicated reset, select bit picks pause or reset for the pin.
// [RULE18] Instruction, address and data travel most significant bit first.
module serial_flash_bus_interface #(
    parameter bit HAS_DEDICATED_RESET = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Serial bus pins
    input wire logic sck_i,
    input wire logic chip_select_b_i,
    input wire logic hw_reset_b_i,
    // Data line 0, serial input
    input wire logic data_line_0_i,
    output logic data_line_0_o,
    output logic data_line_0_oe_b_o,
    // Data line 1, serial output
    input wire logic data_line_1_i,
    output logic data_line_1_o,
    output logic data_line_1_oe_b_o,
    // Data line 2, shared with write protect
    input wire logic data_line_2_i,
    output logic data_line_2_o,
    output logic data_line_2_oe_b_o,
    // Data line 3, shared with pause or reset
    input wire logic data_line_3_i,
    output logic data_line_3_o,
    output logic data_line_3_oe_b_o,
    // Configuration
    input wire logic quad_io_enable_i,
    input wire logic pause_or_init_select_i,
    input wire logic quad_command_mode_i,
    // Transmit side
    input wire logic tx_en_i,
    input wire logic [flash_bus_pkg::BYTE_W-1:0] tx_byte_i,
    // Receive side
    output logic [flash_bus_pkg::BYTE_W-1:0] rx_byte_o,
    output logic rx_valid_o,
    output logic [flash_bus_pkg::BYTE_CNT_W-1:0] byte_index_o,
    // Status
    output logic selected_o,
    output logic paused_o,
    output logic in_reset_o,
    output logic mode3_o,
    // Decoded address
    output logic [flash_bus_pkg::ADDR_W-1:0] addr_o,
    output logic [flash_bus_pkg::SECTOR_W-1:0] sector_o,
    output logic [flash_bus_pkg::BLK32_W-1:0] block32_o,
    output logic [flash_bus_pkg::BLK64_W-1:0] block64_o,
    output logic addr_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Shift a byte left by one bit or one nibble, new bits in at the bottom
    function automatic logic [7:0] shift_msb(input logic [7:0] v, input logic quad,
                                             input logic [3:0] nib);
        logic [7:0] r;
        r = quad ? {v[3:0], nib} : {v[6:0], nib[0]};
        return r;
    endfunction : shift_msb

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [flash_bus_pkg::SYNC_W-1:0] sync1_reg, sync1_next;
    logic [flash_bus_pkg::SYNC_W-1:0] sync2_reg, sync2_next;
    logic sck_d_reg, sck_d_next;
    logic sck_s, cs_b_s, hrst_b_s, sck_rise, sck_fall;
    logic [3:0] din_s;

    // Every pin is foreign to sys_clk, so two stages before use
    always_comb begin
        sync1_next = {data_line_3_i, data_line_2_i, data_line_1_i, data_line_0_i,
                      hw_reset_b_i, chip_select_b_i, sck_i};
        sync2_next = sync1_reg;
        sck_d_next = sync2_reg[flash_bus_pkg::SY_SCK];
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sck_d_reg <= 1'b1; // Matches the synchroniser, so no false rise after reset
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sck_d_reg <= sck_d_next;
        end
    end

    // Edge finding works only from the second stage onward
    assign sck_s = sync2_reg[flash_bus_pkg::SY_SCK];
    assign cs_b_s = sync2_reg[flash_bus_pkg::SY_CS];
    assign hrst_b_s = sync2_reg[flash_bus_pkg::SY_RST];
    assign din_s = sync2_reg[flash_bus_pkg::SY_D0 +: 4];
    assign sck_rise = sck_s & ~sck_d_reg;
    assign sck_fall = ~sck_s & sck_d_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Role of the shared pin
    logic init_active, pause_active, shared_is_init;

    // Dedicated reset ignores quad enable; otherwise the select bit decides
    assign shared_is_init = !HAS_DEDICATED_RESET && pause_or_init_select_i; // see [RULE17]
    assign init_active = HAS_DEDICATED_RESET ? !hrst_b_s // see [RULE4]
                       : (!quad_io_enable_i && shared_is_init && !din_s[3]);
    assign pause_active = !quad_io_enable_i && !shared_is_init && !din_s[3]; // see [RULE1]

    ////////////////////////////////////////////////////////////////////////////
    // Link state and shifters
    flash_bus_pkg::link_state_t state_reg, state_next;
    logic [flash_bus_pkg::BIT_CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic [flash_bus_pkg::BYTE_CNT_W-1:0] byte_cnt_reg, byte_cnt_next;
    logic [flash_bus_pkg::BYTE_W-1:0] rx_sh_reg, rx_sh_next, tx_sh_reg, tx_sh_next;
    logic [flash_bus_pkg::BYTE_W-1:0] rx_byte_reg, rx_byte_next, rx_new;
    logic [flash_bus_pkg::ADDR_W-1:0] addr_sh_reg, addr_sh_next;
    logic rx_valid_reg, rx_valid_next, addr_stb_reg, addr_stb_next;
    logic seen_rise_reg, seen_rise_next, mode3_reg, mode3_next;
    logic [3:0] dout_reg, dout_next, bit_sum;

    always_comb begin
        rx_new = shift_msb(rx_sh_reg, quad_command_mode_i, din_s); // see [RULE18]
        bit_sum = {1'b0, bit_cnt_reg} + (quad_command_mode_i ? flash_bus_pkg::BIT_STEP_QUAD
                                         : flash_bus_pkg::BIT_STEP_SINGLE);
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        byte_cnt_next = byte_cnt_reg;
        rx_sh_next = rx_sh_reg;
        tx_sh_next = tx_sh_reg;
        rx_byte_next = rx_byte_reg;
        addr_sh_next = addr_sh_reg;
        rx_valid_next = 1'b0;
        addr_stb_next = 1'b0;
        seen_rise_next = seen_rise_reg;
        mode3_next = mode3_reg;
        dout_next = dout_reg;
        if (init_active) begin
            state_next = flash_bus_pkg::ST_RESET; // see [RULE5]
        end else begin
            case (state_reg)
                // Wait for a deselected bus before any instruction
                flash_bus_pkg::ST_RESET: begin
                    if (cs_b_s) begin
                        state_next = flash_bus_pkg::ST_STANDBY; // see [RULE16]
                    end
                end
                // Only our own select wakes the block
                flash_bus_pkg::ST_STANDBY: begin
                    if (!cs_b_s) begin
                        state_next = flash_bus_pkg::ST_SHIFT; // see [RULE14]
                        mode3_next = sck_s; // see [RULE7]
                        bit_cnt_next = '0;
                        byte_cnt_next = '0;
                        seen_rise_next = 1'b0;
                    end
                end
                flash_bus_pkg::ST_SHIFT: begin
                    if (cs_b_s) begin
                        state_next = flash_bus_pkg::ST_STANDBY; // see [RULE15]
                    end else if (pause_active) begin
                        state_next = flash_bus_pkg::ST_PAUSE; // see [RULE3]
                    end else if (sck_rise) begin
                        // Sample on the rising edge
                        seen_rise_next = 1'b1;
                        rx_sh_next = rx_new; // see [RULE9]
                        bit_cnt_next = bit_sum[2:0];
                        if (bit_sum[3]) begin
                            rx_byte_next = rx_new;
                            rx_valid_next = 1'b1;
                            tx_sh_next = tx_byte_i;
                            if (byte_cnt_reg != flash_bus_pkg::BYTE_CNT_SAT) begin
                                byte_cnt_next = byte_cnt_reg + 3'h1;
                            end
                            if (byte_cnt_reg >= flash_bus_pkg::ADDR_FIRST_BYTE &&
                                byte_cnt_reg <= flash_bus_pkg::ADDR_LAST_BYTE) begin
                                addr_sh_next = {addr_sh_reg[15:0], rx_new};
                                addr_stb_next = (byte_cnt_reg == flash_bus_pkg::ADDR_LAST_BYTE);
                            end
                        end
                    end else if (sck_fall && seen_rise_reg) begin
                        // Mode 3 opens with a falling edge; nothing to launch yet
                        dout_next = quad_command_mode_i ? tx_sh_reg[7:4] // see [RULE10]
                                  : {2'b00, tx_sh_reg[7], 1'b0}; // see [RULE9]
                        tx_sh_next = shift_msb(tx_sh_reg, quad_command_mode_i, 4'h0);
                    end
                end
                // Progress stays in the counters until pause lifts
                flash_bus_pkg::ST_PAUSE: begin
                    if (cs_b_s) begin
                        state_next = flash_bus_pkg::ST_STANDBY;
                    end else if (!pause_active) begin
                        state_next = flash_bus_pkg::ST_SHIFT; // see [RULE3]
                    end
                end
                default: begin
                    state_next = flash_bus_pkg::ST_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers and status, registered from the next state
    logic [3:0] oe_b_reg, oe_b_next;
    logic sel_reg, sel_next, pause_reg, pause_next, init_reg, init_next;

    // Drive only while shifting and asked to; pause, reset, standby release
    always_comb begin
        oe_b_next = flash_bus_pkg::OE_NONE; // see [RULE2] see [RULE5] see [RULE15]
        if (state_next == flash_bus_pkg::ST_SHIFT && tx_en_i) begin
            oe_b_next = quad_command_mode_i ? flash_bus_pkg::OE_QUAD // see [RULE10]
                      : flash_bus_pkg::OE_SINGLE;
        end
        sel_next = (state_next == flash_bus_pkg::ST_SHIFT) ||
                   (state_next == flash_bus_pkg::ST_PAUSE);
        pause_next = (state_next == flash_bus_pkg::ST_PAUSE);
        init_next = (state_next == flash_bus_pkg::ST_RESET);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= flash_bus_pkg::ST_RESET;
            bit_cnt_reg <= '0;
            byte_cnt_reg <= '0;
            rx_sh_reg <= '0;
            tx_sh_reg <= '0;
            rx_byte_reg <= '0;
            addr_sh_reg <= '0;
            rx_valid_reg <= 1'b0;
            addr_stb_reg <= 1'b0;
            seen_rise_reg <= 1'b0;
            mode3_reg <= 1'b0;
            dout_reg <= '0;
            oe_b_reg <= flash_bus_pkg::OE_NONE;
            sel_reg <= 1'b0;
            pause_reg <= 1'b0;
            init_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            byte_cnt_reg <= byte_cnt_next;
            rx_sh_reg <= rx_sh_next;
            tx_sh_reg <= tx_sh_next;
            rx_byte_reg <= rx_byte_next;
            addr_sh_reg <= addr_sh_next;
            rx_valid_reg <= rx_valid_next;
            addr_stb_reg <= addr_stb_next;
            seen_rise_reg <= seen_rise_next;
            mode3_reg <= mode3_next;
            dout_reg <= dout_next;
            oe_b_reg <= oe_b_next;
            sel_reg <= sel_next;
            pause_reg <= pause_next;
            init_reg <= init_next;
        end
    end

    // Output wiring, flops only
    assign {data_line_3_o, data_line_2_o, data_line_1_o, data_line_0_o} = dout_reg;
    assign data_line_0_oe_b_o = oe_b_reg[0];
    assign data_line_1_oe_b_o = oe_b_reg[1];
    assign data_line_2_oe_b_o = oe_b_reg[2];
    assign data_line_3_oe_b_o = oe_b_reg[3];
    assign rx_byte_o = rx_byte_reg;
    assign rx_valid_o = rx_valid_reg;
    assign byte_index_o = byte_cnt_reg;
    assign selected_o = sel_reg;
    assign paused_o = pause_reg;
    assign in_reset_o = init_reg;
    assign mode3_o = mode3_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Address decoder, fed once the third address byte lands
    flash_addr_decode u_addr_decode (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .addr_i(addr_sh_reg),
        .strobe_i(addr_stb_reg),
        .addr_o(addr_o),
        .sector_o(sector_o),
        .block32_o(block32_o),
        .block64_o(block64_o),
        .addr_valid_o(addr_valid_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence seq_select;
        state_reg == flash_bus_pkg::ST_STANDBY ##1 state_reg == flash_bus_pkg::ST_SHIFT;
    endsequence

    AST_QE_NO_PAUSE: assert property ( // see [RULE1]
        quad_io_enable_i && !init_active |=> state_reg != flash_bus_pkg::ST_PAUSE)
        else $error("pause taken while shared pin is data");

    AST_PAUSE_HIZ: assert property ( // see [RULE2]
        state_reg == flash_bus_pkg::ST_PAUSE |-> data_line_1_oe_b_o && paused_o)
        else $error("serial output driven during pause");

    AST_PAUSE_KEEP: assert property ( // see [RULE3]
        state_reg == flash_bus_pkg::ST_PAUSE && !init_active
        |=> $stable(bit_cnt_reg) && $stable(rx_sh_reg) && $stable(byte_cnt_reg))
        else $error("transfer progress lost in pause");

    AST_DED_RESET: assert property ( // see [RULE4]
        HAS_DEDICATED_RESET && !hrst_b_s |=> state_reg == flash_bus_pkg::ST_RESET ##1 in_reset_o)
        else $error("dedicated reset not obeyed");

    AST_RESET_HIZ: assert property ( // see [RULE5]
        state_reg == flash_bus_pkg::ST_RESET |-> oe_b_reg == flash_bus_pkg::OE_NONE)
        else $error("output driven in reset");

    AST_MODE_LATCH: assert property ( // see [RULE7]
        seq_select |-> mode3_o == $past(sck_s))
        else $error("clock mode not taken from idle clock level");

    AST_RISE_SAMPLE: assert property ( // see [RULE9]
        state_reg == flash_bus_pkg::ST_SHIFT && !cs_b_s && !pause_active && !init_active
        && sck_rise |=> bit_cnt_reg != $past(bit_cnt_reg))
        else $error("rising edge not sampled");

    AST_FALL_NO_SAMPLE: assert property ( // see [RULE9]
        sck_fall |=> $stable(rx_sh_reg))
        else $error("falling edge sampled input");

    AST_QUAD_LINES: assert property ( // see [RULE10]
        !data_line_3_oe_b_o |-> $past(quad_command_mode_i) && !data_line_0_oe_b_o)
        else $error("upper lines driven outside quad command mode");

    AST_DESELECT: assert property ( // see [RULE15]
        state_reg == flash_bus_pkg::ST_STANDBY |-> oe_b_reg == flash_bus_pkg::OE_NONE
        && !selected_o ##1 !rx_valid_o)
        else $error("active while deselected");

    AST_POWERUP: assert property ( // see [RULE16]
        state_reg == flash_bus_pkg::ST_RESET |=> state_reg != flash_bus_pkg::ST_SHIFT)
        else $error("selected without a high chip select first");

endmodule : serial_flash_bus_interface

// ---- include/flash_bus_pkg.sv ----
package flash_bus_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Shift widths
    localparam int BYTE_W = 8;
    localparam int QUAD_W = 4;
    localparam int BIT_CNT_W = 3;
    localparam int BYTE_CNT_W = 3;
    localparam logic [3:0] BIT_STEP_SINGLE = 4'h1;
    localparam logic [3:0] BIT_STEP_QUAD = 4'h4;
    // Bytes after the instruction that carry the address
    localparam logic [2:0] ADDR_FIRST_BYTE = 3'h1;
    localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
    localparam logic [2:0] BYTE_CNT_SAT = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Array geometry
    localparam int ADDR_W = 24;
    localparam logic [23:0] ADDR_MAX = 24'h7F_FFFF;
    localparam int SECTOR_SHIFT = 12;
    localparam int BLK32_SHIFT = 15;
    localparam int BLK64_SHIFT = 16;
    localparam int SECTOR_W = 11;
    localparam int BLK32_W = 8;
    localparam int BLK64_W = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser bit positions
    localparam int SYNC_W = 7;
    localparam int SY_SCK = 0;
    localparam int SY_CS = 1;
    localparam int SY_RST = 2;
    localparam int SY_D0 = 3;

    // Output enables, active low, line 3 in the top bit
    localparam logic [3:0] OE_NONE = 4'hF;
    localparam logic [3:0] OE_QUAD = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'hD;

    ////////////////////////////////////////////////////////////////////////////
    // Link states
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_STANDBY = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_PAUSE = 4'b1000
    } link_state_t;

endpackage : flash_bus_pkg
